// ---- src/tlb_pkg.sv ----
// Purpose: Constants and types of the translation lookaside buffer.
// Assumes: 32-bit APB registers, one aligned word each.
// Notes:   Contract
package tlb_pkg;
    localparam logic [7:0]  OFF_PTE_HI  = 8'h00;
    localparam logic [7:0]  OFF_PTE_LO  = 8'h04;
    localparam logic [7:0]  OFF_CTRL    = 8'h08;
    localparam logic [7:0]  OFF_ENT_IDX = 8'h0C;
    localparam logic [7:0]  OFF_ENT_HI  = 8'h10;
    localparam logic [7:0]  OFF_ENT_LO  = 8'h14;
    localparam logic [7:0]  OFF_ENT_CMD = 8'h18;
    localparam logic [7:0]  OFF_LOAD    = 8'h1C;
    localparam logic [7:0]  OFF_STATUS  = 8'h20;
    localparam logic [7:0]  OFF_CLEAR   = 8'h24;
    localparam logic [7:0]  OFF_ENABLE  = 8'h28;

    localparam logic [31:0] PTE_HI_MASK = 32'hFFFF_FCFF;
    localparam logic [31:0] PTE_LO_MASK = 32'h1FFF_FD7E;
    localparam logic [31:0] PTE_HI_RST  = 32'h0000_0000;
    localparam logic [31:0] PTE_LO_RST  = 32'h0000_0000;

    localparam int CTRL_AT  = 0;
    localparam int CTRL_TF  = 2;
    localparam int CTRL_RC  = 6;
    localparam int CTRL_SV  = 8;
    localparam int CTRL_IX  = 9;
    localparam int LO_V     = 8;
    localparam int CMD_WR   = 0;
    localparam int CMD_INV  = 1;

    localparam int ST_MISS  = 0;
    localparam int ST_PROT  = 1;
    localparam int ST_INIT  = 2;
    localparam int ST_W     = 3;

    typedef struct packed {
        logic [18:0] ppn;
        logic [1:0]  pr;
        logic        sz;
        logic        c;
        logic        d;
        logic        sh;
    } tlb_entry_lo_type;
endpackage : tlb_pkg

// ---- src/tlb_lookup_permission_check.sv ----
// Purpose: Four-way translation buffer with lookup and rights check.
// Assumes: Core request inputs are synchronous to ref_clk.
// Notes:   Lookup answers one cycle after the request.
`timescale 1ns/1ps
module tlb_lookup_permission_check #(
    parameter int NUM_WAYS = 4,
    parameter int NUM_SETS = 32
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        lkReq,
    input  wire logic        lkFetch,
    input  wire logic        lkWrite,
    input  wire logic        lkPriv,
    input  wire logic [31:0] lkVaddr,
    output logic             lkDone,
    output logic             lkHit,
    output logic             lkMiss,
    output logic             lkProtErr,
    output logic             lkInitWrErr,
    output logic             lkCacheable,
    output logic      [31:0] lkPaddr,
    output logic             irq
);
    localparam int WAY_W   = $clog2(NUM_WAYS);
    localparam int SET_W   = $clog2(NUM_SETS);
    localparam int ENTRIES = NUM_WAYS * NUM_SETS;
    localparam int IDX_W   = WAY_W + SET_W;

    logic [31:0]                 pteHiFf;
    logic [31:0]                 pteLoFf;
    logic                        atFf;
    logic                        svFf;
    logic                        ixFf;
    logic [1:0]                  rcFf;
    logic [IDX_W-1:0]            entIdxFf;
    logic [tlb_pkg::ST_W-1:0]    statusFf;
    logic [tlb_pkg::ST_W-1:0]    enableFf;
    logic [31:0]                 prdataFf;
    logic                        preadyFf;
    logic                        pslverrFf;
    logic                        lkDoneFf;
    logic                        lkHitFf;
    logic                        lkMissFf;
    logic                        lkProtFf;
    logic                        lkInitFf;
    logic                        lkCacheFf;
    logic [31:0]                 lkPaddrFf;
    logic                        irqFf;

    // Entry storage; only the in-use flags need a reset value.
    logic [ENTRIES-1:0]          entVFf;
    logic [21:0]                 entVpnFf  [0:ENTRIES-1];
    logic [7:0]                  entAsidFf [0:ENTRIES-1];
    tlb_pkg::tlb_entry_lo_type   entLoFf   [0:ENTRIES-1];

    // APB decode. The access phase lasts two cycles; the reply is a flop.
    wire        accCyc   = psel & penable & ~preadyFf;
    wire        busWr    = accCyc & pwrite;
    wire        busRd    = accCyc & ~pwrite;
    wire        selPteHi = (paddr == tlb_pkg::OFF_PTE_HI);
    wire        selPteLo = (paddr == tlb_pkg::OFF_PTE_LO);
    wire        selCtrl  = (paddr == tlb_pkg::OFF_CTRL);
    wire        selIdx   = (paddr == tlb_pkg::OFF_ENT_IDX);
    wire        selEntHi = (paddr == tlb_pkg::OFF_ENT_HI);
    wire        selEntLo = (paddr == tlb_pkg::OFF_ENT_LO);
    wire        selCmd   = (paddr == tlb_pkg::OFF_ENT_CMD);
    wire        selLoad  = (paddr == tlb_pkg::OFF_LOAD);
    wire        selStat  = (paddr == tlb_pkg::OFF_STATUS);
    wire        selClr   = (paddr == tlb_pkg::OFF_CLEAR);
    wire        selEn    = (paddr == tlb_pkg::OFF_ENABLE);
    wire        mapped   = selPteHi | selPteLo | selCtrl | selIdx
                         | selEntHi | selEntLo | selCmd | selLoad
                         | selStat | selClr | selEn;

    // The current identifier lives in the low byte of PTE high.
    wire [7:0]  curAsid  = pteHiFf[7:0];

    // Software entry maintenance.
    wire        flushAll = busWr & selCtrl & pwdata[tlb_pkg::CTRL_TF];
    wire        loadCmd  = busWr & selLoad;
    wire        mmWrCmd  = busWr & selCmd & pwdata[tlb_pkg::CMD_WR];
    wire        mmInvCmd = busWr & selCmd & pwdata[tlb_pkg::CMD_INV]
                         & ~pwdata[tlb_pkg::CMD_WR];
    wire [4:0]  ldSet    = pteHiFf[16:12]
                         ^ (ixFf ? curAsid[4:0] : 5'h0);
    wire [IDX_W-1:0] ldIdx = {rcFf, ldSet};
    wire [IDX_W-1:0] wrIdx = loadCmd ? ldIdx : entIdxFf;
    wire        doWr     = loadCmd | mmWrCmd;
    wire tlb_pkg::tlb_entry_lo_type newLo = '{
        ppn: pteLoFf[28:10], pr: pteLoFf[6:5], sz: pteLoFf[4],
        c: pteLoFf[3], d: pteLoFf[2], sh: pteLoFf[1]};

    // Readback of the entry that the index register points at.
    tlb_pkg::tlb_entry_lo_type rbLo;
    assign rbLo = entLoFf[entIdxFf];
    wire [31:0] rbHi    = {entVpnFf[entIdxFf], 2'h0, entAsidFf[entIdxFf]};
    wire [31:0] rbLoW   = {3'h0, rbLo.ppn, 1'b0, entVFf[entIdxFf], 1'b0,
                           rbLo.pr, rbLo.sz, rbLo.c, rbLo.d, rbLo.sh, 1'b0};
    wire [31:0] ctrlRd  = {22'h0, ixFf, svFf, rcFf, 5'h0, atFf};
    wire [31:0] rdMux   =
        selPteHi ? pteHiFf :
        selPteLo ? pteLoFf :
        selCtrl  ? ctrlRd :
        selIdx   ? {25'h0, entIdxFf} :
        selEntHi ? rbHi :
        selEntLo ? rbLoW :
        selStat  ? {29'h0, statusFf} :
        selEn    ? {29'h0, enableFf} : 32'h0000_0000;

    // Lookup: one set index shared by every way.
    wire [4:0]  lkSet   = lkVaddr[16:12]
                        ^ (ixFf ? curAsid[4:0] : 5'h0);
    wire        skipAll = svFf & lkPriv;
    // Fetches are reads; data accesses carry their own direction.
    wire        effWr   = lkWrite & ~lkFetch;

    logic [NUM_WAYS-1:0]       hitW;
    logic [NUM_WAYS-1:0]       validW;
    tlb_pkg::tlb_entry_lo_type accLo [0:NUM_WAYS];
    assign accLo[0] = '0;

    genvar w;
    generate
        for (w = 0; w < NUM_WAYS; w++) begin : g_way
            wire [IDX_W-1:0] e = {WAY_W'(w), lkSet};
            wire [21:0] eVpn  = entVpnFf[e];
            wire        vpnHi = (eVpn[21:2] == lkVaddr[31:12]);
            wire        vpnLo = entLoFf[e].sz
                              | (eVpn[1:0] == lkVaddr[11:10]);
            wire        asidOk = entLoFf[e].sh | skipAll
                               | (entAsidFf[e] == curAsid);
            assign validW[w] = entVFf[e];
            assign hitW[w]   = entVFf[e] & vpnHi & vpnLo & asidOk;
            // Ways are one-hot by software discipline, so an OR selects.
            assign accLo[w+1] = accLo[w] | (hitW[w] ? entLoFf[e] : '0);
        end
    endgenerate

    tlb_pkg::tlb_entry_lo_type selLo;
    assign selLo = accLo[NUM_WAYS];
    wire        anyHit = |hitW;
    wire        userOk = selLo.pr[1] & (~effWr | selLo.pr[0]);
    wire        privOk = ~effWr | selLo.pr[0];
    wire        permOk = lkPriv ? privOk : userOk;
    wire        trReq  = lkReq & atFf;
    wire        evMiss = trReq & ~anyHit;
    wire        evProt = trReq & anyHit & ~permOk;
    // Rights are checked first; a refused write is not also an initial write.
    wire        evInit = trReq & anyHit & permOk & effWr & ~selLo.d;
    wire [31:0] trPa   = selLo.sz
                       ? {3'h0, selLo.ppn[18:2], lkVaddr[11:0]}
                       : {3'h0, selLo.ppn, lkVaddr[9:0]};
    wire [31:0] nxtPaddr = atFf ? trPa : lkVaddr;

    // Sticky status: a new event beats a clear in the same cycle.
    wire [tlb_pkg::ST_W-1:0] evVec  = {evInit, evProt, evMiss};
    wire [tlb_pkg::ST_W-1:0] clrVec = (busWr & selClr)
                                    ? pwdata[tlb_pkg::ST_W-1:0] : '0;
    wire [tlb_pkg::ST_W-1:0] nxtStatus = (statusFf & ~clrVec) | evVec;
    wire [tlb_pkg::ST_W-1:0] nxtEnable = (busWr & selEn)
                                    ? pwdata[tlb_pkg::ST_W-1:0] : enableFf;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pteHiFf  <= tlb_pkg::PTE_HI_RST;
            pteLoFf  <= tlb_pkg::PTE_LO_RST;
            atFf     <= 1'b0;
            svFf     <= 1'b0;
            ixFf     <= 1'b0;
            rcFf     <= 2'h0;
            entIdxFf <= '0;
        end else if (busWr) begin
            if (selPteHi) pteHiFf <= pwdata & tlb_pkg::PTE_HI_MASK;
            if (selPteLo) pteLoFf <= pwdata & tlb_pkg::PTE_LO_MASK;
            if (selIdx) entIdxFf <= pwdata[IDX_W-1:0];
            if (selCtrl) begin
                atFf <= pwdata[tlb_pkg::CTRL_AT];
                svFf <= pwdata[tlb_pkg::CTRL_SV];
                ixFf <= pwdata[tlb_pkg::CTRL_IX];
                rcFf <= pwdata[tlb_pkg::CTRL_RC +: 2];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            preadyFf  <= 1'b0;
            pslverrFf <= 1'b0;
            prdataFf  <= 32'h0000_0000;
        end else begin
            preadyFf  <= accCyc;
            pslverrFf <= accCyc & ~mapped;
            if (busRd) prdataFf <= rdMux;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            entVFf <= '0;
        end else if (flushAll) begin
            entVFf <= '0;
        end else if (doWr) begin
            entVFf[wrIdx] <= pteLoFf[tlb_pkg::LO_V];
        end else if (mmInvCmd) begin
            entVFf[entIdxFf] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (doWr) begin
            entVpnFf[wrIdx]  <= pteHiFf[31:10];
            entAsidFf[wrIdx] <= curAsid;
            entLoFf[wrIdx]   <= newLo;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            statusFf <= '0;
            enableFf <= '0;
            irqFf    <= 1'b0;
        end else begin
            statusFf <= nxtStatus;
            enableFf <= nxtEnable;
            irqFf    <= |(nxtStatus & nxtEnable);
        end
    end

    // Results are held until the next request; lkDone marks a new one.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lkDoneFf  <= 1'b0;
            lkHitFf   <= 1'b0;
            lkMissFf  <= 1'b0;
            lkProtFf  <= 1'b0;
            lkInitFf  <= 1'b0;
            lkCacheFf <= 1'b0;
            lkPaddrFf <= 32'h0000_0000;
        end else begin
            lkDoneFf <= lkReq;
            if (lkReq) begin
                lkHitFf   <= atFf & anyHit;
                lkMissFf  <= evMiss;
                lkProtFf  <= evProt;
                lkInitFf  <= evInit;
                lkCacheFf <= atFf & anyHit & selLo.c;
                lkPaddrFf <= nxtPaddr;
            end
        end
    end

    assign prdata      = prdataFf;
    assign pready      = preadyFf;
    assign pslverr     = pslverrFf;
    assign lkDone      = lkDoneFf;
    assign lkHit       = lkHitFf;
    assign lkMiss      = lkMissFf;
    assign lkProtErr   = lkProtFf;
    assign lkInitWrErr = lkInitFf;
    assign lkCacheable = lkCacheFf;
    assign lkPaddr     = lkPaddrFf;
    assign irq         = irqFf;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_miss_report: assert property (
        lkReq && atFf && hitW == '0 |=> lkMiss && !lkHit && lkDone)
        else $error("translated access without hit gave no miss");
    a_invalid_nohit: assert property (
        lkReq && validW == '0 |=> !lkHit)
        else $error("hit reported on a set with no entry in use");
    a_off_quiet: assert property (
        lkReq && !atFf |=> !lkMiss && !lkProtErr && !lkInitWrErr
            && lkPaddr == $past(lkVaddr))
        else $error("exception or translation while mapping disabled");
    a_flush_all: assert property (
        flushAll |=> entVFf == '0)
        else $error("flush trigger left an entry in use");
    a_user_rights: assert property (
        trReq && anyHit && !lkPriv && !selLo.pr[1] |=> lkProtErr)
        else $error("user access to privileged page not refused");
    a_priv_write: assert property (
        trReq && anyHit && lkPriv && effWr && !selLo.pr[0] |=> lkProtErr)
        else $error("privileged write to read-only page not refused");
    a_init_write: assert property (
        trReq && anyHit && effWr && permOk && !selLo.d |=> lkInitWrErr)
        else $error("write to unwritten page raised no initial write");
    a_read_clean: assert property (
        lkReq && !effWr |=> !lkInitWrErr)
        else $error("read raised an initial write");
    a_cache_pass: assert property (
        trReq && anyHit |=> lkCacheable == $past(selLo.c))
        else $error("cache bit not passed from the hit entry");
    a_load_index: assert property (
        loadCmd && pteLoFf[tlb_pkg::LO_V] |=>
            entVFf[{$past(rcFf), $past(pteHiFf[16:12] ^
                (ixFf ? curAsid[4:0] : 5'h0))}])
        else $error("entry load missed the indexed slot");
    a_irq_level: assert property (
        irq == |(statusFf & enableFf))
        else $error("interrupt does not follow enabled status");
    a_apb_answer: assert property (
        psel && penable && !pready |=> pready)
        else $error("register access not answered in two cycles");

    c_hit: cover property (lkReq && atFf && anyHit ##1 lkHit);
    c_miss: cover property (lkReq && atFf ##1 lkMiss);
    c_prot: cover property (lkReq && atFf ##1 lkProtErr);
    c_flush: cover property (flushAll ##1 lkReq);
endmodule : tlb_lookup_permission_check

// ---- verification/tlb_core_model.sv ----
// Purpose: Core-side requester that issues fetch and data lookups.
// Assumes: Requests change just after a rising edge of ref_clk.
// Notes:   On release, lkVaddr and lkWrite show the inverse of their last value.
`timescale 1ns/1ps
module tlb_core_model (
    input  wire logic        ref_clk,
    output logic             lkReq,
    output logic             lkFetch,
    output logic             lkWrite,
    output logic             lkPriv,
    output logic      [31:0] lkVaddr
);
    initial begin
        lkReq   = 1'b0;
        lkFetch = 1'b0;
        lkWrite = 1'b0;
        lkPriv  = 1'b0;
        lkVaddr = 32'h0000_0000;
    end

    // A held request is a burst; the caller ends it with rest.
    task automatic issue(input logic f, input logic w, input logic p,
                         input logic [31:0] v);
        @(posedge ref_clk);
        lkReq   <= 1'b1;
        lkFetch <= f;
        lkWrite <= w;
        lkPriv  <= p;
        lkVaddr <= v;
    endtask : issue

    // Idle address and write lines must not look like a stale request, so they change.
    task automatic rest(input int gap);
        @(posedge ref_clk);
        lkReq   <= 1'b0;
        lkVaddr <= ~lkVaddr;
        lkWrite <= ~lkWrite;
        repeat (gap) @(posedge ref_clk);
    endtask : rest
endmodule : tlb_core_model

// ---- verification/tlb_lookup_permission_check_tb_top.sv ----
// Purpose: Self-checking bench for the lookup and rights check block.
// Assumes: One clock; bus and lookup results are noted in queues.
// Notes:   Page numbers and offsets come from a fixed random seed.
`timescale 1ns/1ps
module tlb_lookup_permission_check_tb_top;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata, lkVaddr, lkPaddr, va;
    logic        pready, pslverr, lkReq, lkFetch, lkWrite, lkPriv, irq;
    logic        lkDone, lkHit, lkMiss, lkProtErr, lkInitWrErr, lkCacheable;
    logic [37:0] lkQ[$];
    logic [33:0] apbQ[$];
    logic [1:0]  entPr;
    logic        entD, entC, entSz, mapOn;
    logic [18:0] entPpn;
    logic [7:0]  address_space_identifier;
    int          mismatches = 0;
    int          checked    = 0;
    int          cycles     = 0;

    always #25 ref_clk = ~ref_clk;

    tlb_lookup_permission_check dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lkReq(lkReq), .lkFetch(lkFetch),
        .lkWrite(lkWrite), .lkPriv(lkPriv), .lkVaddr(lkVaddr),
        .lkDone(lkDone), .lkHit(lkHit), .lkMiss(lkMiss),
        .lkProtErr(lkProtErr), .lkInitWrErr(lkInitWrErr),
        .lkCacheable(lkCacheable), .lkPaddr(lkPaddr), .irq(irq)
    );

    tlb_core_model core (
        .ref_clk(ref_clk), .lkReq(lkReq), .lkFetch(lkFetch),
        .lkWrite(lkWrite), .lkPriv(lkPriv), .lkVaddr(lkVaddr)
    );

    task automatic test_done();
        if (mismatches == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    task automatic fail(input string msg);
        mismatches++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask : fail

    task automatic cmp_lk(input logic [36:0] got);
        logic [37:0] e;
        checked++;
        if (lkQ.size() == 0) begin
            fail("lookup answer with no request");
        end else begin
            e = lkQ.pop_front();
            if (!e[37])
                got[31:0] = e[31:0];
            if (got !== e[36:0])
                fail($sformatf("lookup %h, wanted %h", got, e[36:0]));
        end
    endtask : cmp_lk

    task automatic cmp_apb(input logic [32:0] got);
        logic [33:0] e;
        checked++;
        if (apbQ.size() == 0) begin
            fail("bus answer with no request");
        end else begin
            e = apbQ.pop_front();
            if (!e[33])
                got[31:0] = e[31:0];
            if (got !== e[32:0])
                fail($sformatf("bus %h, wanted %h", got, e[32:0]));
        end
    endtask : cmp_apb

    task automatic cmp_irq(input logic e);
        repeat (2) @(posedge ref_clk);
        checked++;
        if (irq !== e)
            fail("interrupt level wrong");
    endtask : cmp_irq

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            fail("run timed out");
            test_done();
        end
        if (lkDone === 1'b1)
            cmp_lk({lkHit, lkMiss, lkProtErr, lkInitWrErr, lkCacheable,
                    lkPaddr});
        if (pready === 1'b1)
            cmp_apb({pslverr, prdata});
    end

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [33:0] e);
        int n;
        apbQ.push_back(e);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, {2'b00, 32'h0000_0000});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0000_0000, {2'b10, d});
    endtask : rd

    task automatic look(input logic f, input logic w, input logic p,
                        input logic [31:0] v, input logic h);
        logic        ok;
        logic        we;
        logic [31:0] pa;
        // A fetch is a read whatever the write line shows.
        we = w && !f;
        ok = p ? (!we || entPr[0]) : (entPr[1] && (!we || entPr[0]));
        pa = entSz ? {3'b000, entPpn[18:2], v[11:0]}
                   : {3'b000, entPpn, v[9:0]};
        if (!mapOn)
            lkQ.push_back({1'b1, 5'b00000, v});
        else
            lkQ.push_back({h, h, !h, h && !ok, h && ok && we && !entD,
                           h && entC, pa});
        core.issue(f, w, p, v);
    endtask : look

    // Every load goes to way zero of its set, so two ways never match.
    task automatic load(input logic [1:0] pr, input logic sz, input logic c,
                        input logic d, input logic sh);
        entPr  = pr;
        entD   = d;
        entC   = c;
        entSz  = sz;
        entPpn = 19'($urandom);
        wr(tlb_pkg::OFF_PTE_HI, {va[31:10], 2'b00, address_space_identifier});
        wr(tlb_pkg::OFF_PTE_LO, {3'b000, entPpn, 3'b010, pr, sz, c, d, sh,
                                 1'b0});
        wr(tlb_pkg::OFF_LOAD, 32'h0000_0001);
    endtask : load

    initial begin
        void'($urandom(55));
        mapOn = 1'b0;
        va    = $urandom;
        address_space_identifier  = 8'($urandom);
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(tlb_pkg::OFF_CTRL, 32'h0000_0000);
        rd(tlb_pkg::OFF_PTE_HI, 32'h0000_0000);
        rd(tlb_pkg::OFF_STATUS, 32'h0000_0000);
        apb(1'b0, 8'h3C, 32'h0000_0000, {2'b01, 32'h0000_0000});
        look(1'($urandom), 1'($urandom), 1'($urandom), va, 1'b0);
        core.rest(0);
        wr(tlb_pkg::OFF_CTRL, 32'h0000_0001);
        mapOn = 1'b1;
        load(2'b11, 1'b1, 1'b1, 1'b1, 1'b0);
        wr(tlb_pkg::OFF_ENT_IDX, {27'h000_0000, va[16:12]});
        rd(tlb_pkg::OFF_ENT_HI, {va[31:10], 2'b00, address_space_identifier});
        look(1'b0, 1'b1, 1'b0, va, 1'b1);
        look(1'b1, 1'b0, 1'b0, {va[31:12], 12'($urandom)}, 1'b1);
        look(1'b0, 1'b0, 1'b1, va ^ 32'h0000_1000, 1'b0);
        core.rest(2);
        cmp_irq(1'b0);
        wr(tlb_pkg::OFF_ENABLE, 32'h0000_0001);
        cmp_irq(1'b1);
        rd(tlb_pkg::OFF_STATUS, 32'h0000_0001);
        wr(tlb_pkg::OFF_CLEAR, 32'h0000_0001);
        rd(tlb_pkg::OFF_STATUS, 32'h0000_0000);
        cmp_irq(1'b0);
        for (int pr = 0; pr < 4; pr++) begin
            load(2'(pr), 1'b1, pr[0], 1'b0, 1'b1);
            wr(tlb_pkg::OFF_PTE_HI, {va[31:10], 2'b00, ~address_space_identifier});
            for (int m = 0; m < 4; m++)
                look(1'($urandom), m[0], m[1],
                     {va[31:12], 12'($urandom)}, 1'b1);
            core.rest(0);
        end
        load(2'b11, 1'b1, 1'b1, 1'b1, 1'b0);
        wr(tlb_pkg::OFF_PTE_HI, {va[31:10], 2'b00, ~address_space_identifier});
        look(1'b0, 1'b0, 1'b1, va, 1'b0);
        core.rest(0);
        wr(tlb_pkg::OFF_CTRL, 32'h0000_0105);
        look(1'b0, 1'b0, 1'b1, va, 1'b0);
        core.rest(0);
        load(2'b11, 1'b1, 1'b1, 1'b1, 1'b0);
        wr(tlb_pkg::OFF_PTE_HI, {va[31:10], 2'b00, ~address_space_identifier});
        look(1'b0, 1'b0, 1'b1, va, 1'b1);
        look(1'b0, 1'b0, 1'b0, va, 1'b0);
        core.rest(0);
        wr(tlb_pkg::OFF_CTRL, 32'h0000_0205);
        load(2'b11, 1'b0, 1'b0, 1'b1, 1'b0);
        wr(tlb_pkg::OFF_ENT_IDX, {27'h000_0000, va[16:12] ^ address_space_identifier[4:0]});
        rd(tlb_pkg::OFF_ENT_HI, {va[31:10], 2'b00, address_space_identifier});
        look(1'b0, 1'b1, 1'b0, {va[31:10], 10'($urandom)}, 1'b1);
        look(1'b0, 1'b1, 1'b0, va ^ 32'h0000_0400, 1'b0);
        core.rest(0);
        wr(tlb_pkg::OFF_ENT_CMD, 32'h0000_0002);
        look(1'b0, 1'b0, 1'b1, va, 1'b0);
        core.rest(4);
        if (lkQ.size() != 0 || apbQ.size() != 0)
            fail("notes left unanswered");
        test_done();
    end
endmodule : tlb_lookup_permission_check_tb_top
